// ==== verilog/link_irq_pkg.sv ====
`default_nettype none
package link_irq_pkg;
	localparam int EVT_W = 18;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// word addresses on the plain register port
	localparam logic [3:0] ADDR_EVT_SET = 4'h0;
	localparam logic [3:0] ADDR_EVT_CLR = 4'h1;
	localparam logic [3:0] ADDR_MASK_SET = 4'h2;
	localparam logic [3:0] ADDR_MASK_CLR = 4'h3;
	localparam logic [3:0] ADDR_MASKED = 4'h4;
	// bit positions
	localparam int B_BUS_RESET = 17;
	localparam int B_SELF_DONE = 16;
	localparam int B_SELF_STICKY = 15;
	localparam int B_LOCK_ERR = 9;
	localparam int B_POSTED_ERR = 8;
	localparam int B_ISO_RX = 7;
	localparam int B_ISO_TX = 6;
	localparam int B_RSP_PKT = 5;
	localparam int B_REQ_PKT = 4;
	localparam int B_RX_RSP = 3;
	localparam int B_RX_REQ = 2;
	localparam int B_TX_RSP = 1;
	localparam int B_TX_REQ = 0;
	// latched bits; reserved 14..10 and summaries 7..6 excluded
	localparam logic [17:0] LATCH_MASK = 18'h3833F;
	localparam logic [17:0] EVT_RESET = 18'h00000;
	localparam logic [17:0] MASK_RESET = 18'h00000;
	localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage
`default_nettype wire

// ==== verilog/link_interrupt_event_latch.sv ====
`timescale 1ns/1ps
`default_nettype none
module link_interrupt_event_latch (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        clkEn,
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrStb,
	input  wire logic        regRdStb,
	output logic      [31:0] regRdData,
	output logic             irq,
	input  wire logic        busResetEntered,
	input  wire logic        selfIdentDone,
	input  wire logic        lockRespNoAck,
	input  wire logic        postedWriteHostErr,
	input  wire logic [7:0]  isoRxEvents,
	input  wire logic [7:0]  isoRxMask,
	input  wire logic [7:0]  isoTxEvents,
	input  wire logic [7:0]  isoTxMask,
	input  wire logic        rspPacketStored,
	input  wire logic        reqPacketStored,
	input  wire logic        rxRspDescDone,
	input  wire logic        rxRspDescIrq,
	input  wire logic        rxReqDescDone,
	input  wire logic        rxReqDescIrq,
	input  wire logic        txRspCmdDone,
	input  wire logic        txRspCmdIrq,
	input  wire logic        txReqCmdDone,
	input  wire logic        txReqCmdIrq
);
	typedef struct packed {
		logic [17:0] evt;
		logic [17:0] mask;
		logic [31:0] rd;
	} state_t;

	state_t stQ;
	state_t stD;
	logic [17:0] hwSet;
	logic [17:0] view;

	function automatic logic [17:0] low18(input logic [31:0] w);
		return w[17:0];
	endfunction

	always_comb begin
		hwSet = '0;
		hwSet[link_irq_pkg::B_BUS_RESET] = busResetEntered;
		hwSet[link_irq_pkg::B_SELF_DONE] = selfIdentDone;
		hwSet[link_irq_pkg::B_SELF_STICKY] = selfIdentDone;
		hwSet[link_irq_pkg::B_LOCK_ERR] = lockRespNoAck;
		hwSet[link_irq_pkg::B_POSTED_ERR] = postedWriteHostErr;
		hwSet[link_irq_pkg::B_RSP_PKT] = rspPacketStored;
		hwSet[link_irq_pkg::B_REQ_PKT] = reqPacketStored;
		hwSet[link_irq_pkg::B_RX_RSP] = rxRspDescDone & rxRspDescIrq;
		hwSet[link_irq_pkg::B_RX_REQ] = rxReqDescDone & rxReqDescIrq;
		hwSet[link_irq_pkg::B_TX_RSP] = txRspCmdDone & txRspCmdIrq;
		hwSet[link_irq_pkg::B_TX_REQ] = txReqCmdDone & txReqCmdIrq;
	end

	always_comb begin
		view = stQ.evt & link_irq_pkg::LATCH_MASK;
		view[link_irq_pkg::B_ISO_RX] = |(isoRxEvents & isoRxMask);
		view[link_irq_pkg::B_ISO_TX] = |(isoTxEvents & isoTxMask);
	end

	assign irq = |(view & stQ.mask);

	always_comb begin
		stD = stQ;
		if (regWrStb && regAddr == link_irq_pkg::ADDR_EVT_CLR) begin
			stD.evt = stD.evt & ~low18(regWrData);
		end
		if (regWrStb && regAddr == link_irq_pkg::ADDR_EVT_SET) begin
			stD.evt = stD.evt | low18(regWrData);
		end
		if (regWrStb && regAddr == link_irq_pkg::ADDR_MASK_SET) begin
			stD.mask = stD.mask | low18(regWrData);
		end
		if (regWrStb && regAddr == link_irq_pkg::ADDR_MASK_CLR) begin
			stD.mask = stD.mask & ~low18(regWrData);
		end
		// hardware sets win over a simultaneous software clear
		stD.evt = stD.evt | hwSet;
		if (busResetEntered && !selfIdentDone) begin
			stD.evt[link_irq_pkg::B_SELF_DONE] = 1'b0;
		end
		stD.evt = stD.evt & link_irq_pkg::LATCH_MASK;
		stD.mask = stD.mask & link_irq_pkg::LATCH_MASK
			| stD.mask & 18'h000C0;
		stD.rd = link_irq_pkg::RD_ZERO;
		if (regRdStb) begin
			unique case (regAddr)
				link_irq_pkg::ADDR_EVT_SET,
				link_irq_pkg::ADDR_EVT_CLR: stD.rd = {14'h0000, view};
				link_irq_pkg::ADDR_MASK_SET,
				link_irq_pkg::ADDR_MASK_CLR: stD.rd = {14'h0000, stQ.mask};
				link_irq_pkg::ADDR_MASKED: stD.rd = {14'h0000, view & stQ.mask};
				default: stD.rd = link_irq_pkg::RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stQ.evt <= link_irq_pkg::EVT_RESET;
			stQ.mask <= link_irq_pkg::MASK_RESET;
			stQ.rd <= link_irq_pkg::RD_ZERO;
		end else if (clkEn) begin
			stQ <= stD;
		end
	end

	assign regRdData = stQ.rd;

	// bus reset alone: 17 set and 16 cleared next cycle
	property p_bus_reset_event;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && busResetEntered && !selfIdentDone
			|=> stQ.evt[17] && !stQ.evt[16];
	endproperty
	a_bus_reset_event: assert property (p_bus_reset_event) else $error("bus reset");
	property p_clr16;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && busResetEntered && !selfIdentDone |=> !view[16];
	endproperty
	a_clr16: assert property (p_clr16) else $error("bit16 not cleared");
	property p_selfdone;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && selfIdentDone |=> stQ.evt[16] && stQ.evt[15];
	endproperty
	a_selfdone: assert property (p_selfdone) else $error("self id");
	property p_sticky;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && stQ.evt[15] && busResetEntered && !regWrStb
			|=> stQ.evt[15];
	endproperty
	a_sticky: assert property (p_sticky) else $error("bit15 lost");
	property p_rsvd;
		@(posedge core_clk) disable iff (!arst_n)
		regRdData[31:18] == 14'h0000 && regRdData[14:10] == 5'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved nonzero");
	property p_isorx;
		@(posedge core_clk) disable iff (!arst_n)
		view[7] == |(isoRxEvents & isoRxMask);
	endproperty
	a_isorx: assert property (p_isorx) else $error("iso rx");
	property p_isotx;
		@(posedge core_clk) disable iff (!arst_n)
		view[6] == |(isoTxEvents & isoTxMask);
	endproperty
	a_isotx: assert property (p_isotx) else $error("iso tx");
	property p_qual;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && txReqCmdDone && !txReqCmdIrq && !stQ.evt[0]
			&& !regWrStb |=> !stQ.evt[0];
	endproperty
	a_qual: assert property (p_qual) else $error("tx req set");
	property p_clear;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && regWrStb && regAddr == link_irq_pkg::ADDR_EVT_CLR
			&& regWrData[9] && !lockRespNoAck |=> !stQ.evt[9];
	endproperty
	a_clear: assert property (p_clear) else $error("clear");
	property p_set;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && regWrStb && regAddr == link_irq_pkg::ADDR_EVT_SET
			&& regWrData[8] |=> stQ.evt[8];
	endproperty
	a_set: assert property (p_set) else $error("set");

	// every source strobe lands one enabled cycle later
	property p_lock;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && lockRespNoAck
			|=> stQ.evt[link_irq_pkg::B_LOCK_ERR];
	endproperty
	a_lock: assert property (p_lock) else $error("lock");

	property p_posted;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && postedWriteHostErr
			|=> stQ.evt[link_irq_pkg::B_POSTED_ERR];
	endproperty
	a_posted: assert property (p_posted) else $error("posted");

	property p_rsppkt;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && rspPacketStored
			|=> stQ.evt[link_irq_pkg::B_RSP_PKT];
	endproperty
	a_rsppkt: assert property (p_rsppkt) else $error("rsp pkt");

	property p_reqpkt;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && reqPacketStored
			|=> stQ.evt[link_irq_pkg::B_REQ_PKT];
	endproperty
	a_reqpkt: assert property (p_reqpkt) else $error("req pkt");

	property p_rxrsp;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && rxRspDescDone && rxRspDescIrq
			|=> stQ.evt[link_irq_pkg::B_RX_RSP];
	endproperty
	a_rxrsp: assert property (p_rxrsp) else $error("rx rsp");

	property p_rxreq;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && rxReqDescDone && rxReqDescIrq
			|=> stQ.evt[link_irq_pkg::B_RX_REQ];
	endproperty
	a_rxreq: assert property (p_rxreq) else $error("rx req");

	property p_txrsp;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && txRspCmdDone && txRspCmdIrq
			|=> stQ.evt[link_irq_pkg::B_TX_RSP];
	endproperty
	a_txrsp: assert property (p_txrsp) else $error("tx rsp");

	property p_txreq;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && txReqCmdDone && txReqCmdIrq
			|=> stQ.evt[link_irq_pkg::B_TX_REQ];
	endproperty
	a_txreq: assert property (p_txreq) else $error("tx req");

	// completions without the qualifier must not raise their bit
	property p_rxrsp_q;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && rxRspDescDone && !rxRspDescIrq && !regWrStb
			&& !stQ.evt[link_irq_pkg::B_RX_RSP]
			|=> !stQ.evt[link_irq_pkg::B_RX_RSP];
	endproperty
	a_rxrsp_q: assert property (p_rxrsp_q) else $error("rx rsp q");

	property p_rxreq_q;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && rxReqDescDone && !rxReqDescIrq && !regWrStb
			&& !stQ.evt[link_irq_pkg::B_RX_REQ]
			|=> !stQ.evt[link_irq_pkg::B_RX_REQ];
	endproperty
	a_rxreq_q: assert property (p_rxreq_q) else $error("rx req q");

	property p_txrsp_q;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && txRspCmdDone && !txRspCmdIrq && !regWrStb
			&& !stQ.evt[link_irq_pkg::B_TX_RSP]
			|=> !stQ.evt[link_irq_pkg::B_TX_RSP];
	endproperty
	a_txrsp_q: assert property (p_txrsp_q) else $error("tx rsp q");

	// self-id in the same cycle as bus reset keeps bit 16
	property p_both;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && busResetEntered && selfIdentDone
			|=> stQ.evt[17] && stQ.evt[16];
	endproperty
	a_both: assert property (p_both) else $error("both");

	property p_hold;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && stQ.evt[link_irq_pkg::B_LOCK_ERR] && !regWrStb
			|=> stQ.evt[link_irq_pkg::B_LOCK_ERR];
	endproperty
	a_hold: assert property (p_hold) else $error("hold");

	property p_hold5;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && stQ.evt[link_irq_pkg::B_RSP_PKT] && !regWrStb
			|=> stQ.evt[link_irq_pkg::B_RSP_PKT];
	endproperty
	a_hold5: assert property (p_hold5) else $error("hold5");

	property p_zero;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && regWrStb && regAddr == link_irq_pkg::ADDR_EVT_CLR
			&& !regWrData[8] && stQ.evt[8] |=> stQ.evt[8];
	endproperty
	a_zero: assert property (p_zero) else $error("zero clr");

	property p_sumset;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && regWrStb && regAddr == link_irq_pkg::ADDR_EVT_SET
			|=> !stQ.evt[link_irq_pkg::B_ISO_RX] && !stQ.evt[6];
	endproperty
	a_sumset: assert property (p_sumset) else $error("sum set");

	// a low enable must freeze every register, read data included
	property p_freeze;
		@(posedge core_clk) disable iff (!arst_n)
		!clkEn
			|=> $stable(stQ.evt) && $stable(stQ.mask) && $stable(regRdData);
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze");

	property p_idle;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && !regRdStb
			|=> regRdData == link_irq_pkg::RD_ZERO;
	endproperty
	a_idle: assert property (p_idle) else $error("idle read");

	property p_isord;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && regRdStb && regAddr == link_irq_pkg::ADDR_EVT_SET
			|=> regRdData[7] == $past(view[7]);
	endproperty
	a_isord: assert property (p_isord) else $error("iso rx rd");

	property p_isotd;
		@(posedge core_clk) disable iff (!arst_n)
		clkEn && regRdStb && regAddr == link_irq_pkg::ADDR_EVT_SET
			|=> regRdData[6] == $past(view[6]);
	endproperty
	a_isotd: assert property (p_isotd) else $error("iso tx rd");

	property p_irq;
		@(posedge core_clk) disable iff (!arst_n)
		stQ.mask[link_irq_pkg::B_LOCK_ERR]
			&& stQ.evt[link_irq_pkg::B_LOCK_ERR] |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq");

	property p_evtrsvd;
		@(posedge core_clk) disable iff (!arst_n)
		(stQ.evt & ~link_irq_pkg::LATCH_MASK) == 18'h00000;
	endproperty
	a_evtrsvd: assert property (p_evtrsvd) else $error("rsvd evt");

	c_bus_reset_event: cover property (@(posedge core_clk) busResetEntered);
	c_irq: cover property (@(posedge core_clk) irq);
	c_read: cover property (@(posedge core_clk) regRdStb ##1 regRdData != 0);
	c_sticky: cover property (@(posedge core_clk) busResetEntered && stQ.evt[15]);
	c_race: cover property (@(posedge core_clk) regWrStb && lockRespNoAck
		&& regAddr == link_irq_pkg::ADDR_EVT_CLR);
endmodule // link_interrupt_event_latch
`default_nettype wire

// ==== verification/link_event_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// stand-in for link and dma contexts raising one-cycle strobes
module link_event_src (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [13:0] req,
	output logic      [13:0] ev
);
	// registered so every strobe follows req one cycle later and lasts as long as req
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) ev <= 14'h0000;
		else ev <= req;
	end
endmodule // link_event_src
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [31:0] regWrData = 32'h00000000;
	logic        regWrStb = 1'b0;
	logic        regRdStb = 1'b0;
	logic        clkEn = 1'b1;
	logic [31:0] regRdData;
	logic        irq;
	logic [13:0] req = 14'h0000;
	logic [13:0] ev;
	logic [7:0]  isoRxEvents = 8'h00;
	logic [7:0]  isoRxMask = 8'h00;
	logic [7:0]  isoTxEvents = 8'h00;
	logic [7:0]  isoTxMask = 8'h00;
	int          num_errors = 0;
	int          tests_run = 0;
	int          cycles = 0;
	// done without qualifier must leave its bit clear
	logic [13:0] rq [14] = '{14'h0001, 14'h0002, 14'h0004, 14'h0008, 14'h0010,
		14'h0020, 14'h0040, 14'h00C0, 14'h0100, 14'h0300, 14'h0400,
		14'h0C00, 14'h1000, 14'h3000};
	logic [17:0] ex [14] = '{18'h20000, 18'h18000, 18'h00200, 18'h00100,
		18'h00020, 18'h00010, 18'h00000, 18'h00008, 18'h00000, 18'h00004,
		18'h00000, 18'h00002, 18'h00000, 18'h00001};
	link_event_src i_src (.core_clk, .arst_n, .req, .ev);
	link_interrupt_event_latch i_dut (.core_clk, .arst_n, .clkEn,
		.regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .irq,
		.busResetEntered(ev[0]), .selfIdentDone(ev[1]),
		.lockRespNoAck(ev[2]), .postedWriteHostErr(ev[3]),
		.isoRxEvents, .isoRxMask, .isoTxEvents, .isoTxMask,
		.rspPacketStored(ev[4]), .reqPacketStored(ev[5]),
		.rxRspDescDone(ev[6]), .rxRspDescIrq(ev[7]),
		.rxReqDescDone(ev[8]), .rxReqDescIrq(ev[9]),
		.txRspCmdDone(ev[10]), .txRspCmdIrq(ev[11]),
		.txReqCmdDone(ev[12]), .txReqCmdIrq(ev[13]));
	always #25 core_clk = ~core_clk;
	// runaway guard, the sequence needs about 300 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			results();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t saw %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		#1 check(regRdData, exp);
	endtask
	task automatic pulse(input logic [13:0] r);
		@(posedge core_clk);
		req <= r;
		@(posedge core_clk);
		req <= 14'h0000;
		@(posedge core_clk);
	endtask
	task automatic results();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		rd(link_irq_pkg::ADDR_EVT_SET, 32'h00000000);
		rd(link_irq_pkg::ADDR_MASK_SET, 32'h00000000);
		for (int i = 0; i < 14; i++) begin
			pulse(rq[i]);
			rd(4'h0, {14'h0000, ex[i]});
			wr(link_irq_pkg::ADDR_EVT_CLR, 32'h00000000);
			rd(4'h1, {14'h0000, ex[i]});
			wr(link_irq_pkg::ADDR_EVT_CLR, 32'hFFFFFFFF);
			rd(link_irq_pkg::ADDR_EVT_SET, 32'h00000000);
		end
		$display("event sources done");
		pulse(14'h0002);
		pulse(14'h0001);
		rd(link_irq_pkg::ADDR_EVT_SET, 32'h00028000);
		wr(link_irq_pkg::ADDR_EVT_CLR, 32'hFFFFFFFF);
		wr(link_irq_pkg::ADDR_EVT_SET, 32'hFFFFFFFF);
		rd(link_irq_pkg::ADDR_EVT_SET, 32'h0003833F);
		wr(link_irq_pkg::ADDR_EVT_CLR, 32'hFFFFFFFF);
		isoRxEvents <= 8'h10;
		isoTxEvents <= 8'h01;
		isoTxMask <= 8'hFE;
		rd(link_irq_pkg::ADDR_EVT_SET, 32'h00000000);
		isoRxMask <= 8'h10;
		isoTxMask <= 8'h01;
		rd(link_irq_pkg::ADDR_EVT_SET, 32'h000000C0);
		$display("summary bits done");
		isoRxMask <= 8'h00;
		isoTxMask <= 8'h00;
		wr(link_irq_pkg::ADDR_MASK_SET, 32'h00000200);
		pulse(14'h0004);
		#1 check({31'h0, irq}, 32'h00000001);
		rd(link_irq_pkg::ADDR_MASKED, 32'h00000200);
		wr(link_irq_pkg::ADDR_MASK_CLR, 32'h00000200);
		#1 check({31'h0, irq}, 32'h00000000);
		rd(4'hF, 32'h00000000);
		$display("interrupt and map done");
		wr(link_irq_pkg::ADDR_EVT_CLR, 32'hFFFFFFFF);
		wr(link_irq_pkg::ADDR_MASK_SET, 32'hFFFFFFFF);
		rd(link_irq_pkg::ADDR_MASK_CLR, 32'h000383FF);
		#1 check({31'h0, irq}, 32'h00000000);
		@(posedge core_clk);
		isoRxMask <= 8'h10;
		@(posedge core_clk);
		#1 check({31'h0, irq}, 32'h00000001);
		rd(link_irq_pkg::ADDR_MASKED, 32'h00000080);
		wr(link_irq_pkg::ADDR_MASK_CLR, 32'hFFFFFFFF);
		isoRxMask <= 8'h00;
		// hardware set and software clear meet in one cycle
		@(posedge core_clk);
		req <= 14'h0004;
		@(posedge core_clk);
		req <= 14'h0000;
		regAddr <= link_irq_pkg::ADDR_EVT_CLR;
		regWrData <= 32'h00000200;
		regWrStb <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
		rd(link_irq_pkg::ADDR_EVT_SET, 32'h00000200);
		wr(link_irq_pkg::ADDR_EVT_CLR, 32'h00000200);
		clkEn <= 1'b0;
		pulse(14'h0008);
		clkEn <= 1'b1;
		rd(link_irq_pkg::ADDR_EVT_SET, 32'h00000000);
		pulse(14'h0008);
		rd(link_irq_pkg::ADDR_EVT_SET, 32'h00000100);
		$display("set priority and freeze done");
		results();
	end
endmodule // tb_top
`default_nettype wire
